// >>> pcg_pin_config_gpio.sv
// Pin configuration block with an AXI4-Lite register slave.
`timescale 1ns/1ps
module pcg_pin_config_gpio
  import pcg_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic [PCG_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [PCG_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [7:0]            pad_input_level,
  output logic [7:0]                 pad_output_value,
  output logic [7:0]                 padOe,
  input  wire logic                  scanEnabled,
  input  wire logic                  clockFunction,
  input  wire logic                  txEnvelope,
  input  wire logic                  txActive,
  input  wire logic                  genericSecureSignal,
  input  wire logic                  rxEnvelope,
  input  wire logic                  rxActive,
  input  wire logic                  rxBits,
  output logic                       signalOutputPin,
  output logic                       signalOutputOe,
  output logic                       fastSwitch
);

  logic [1:0] rstSync;
  logic       rstN;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  logic [7:0]      padOutputEnable;
  logic [7:0]      padOutputValue;
  logic [7:0]      padInputLevel;
  logic [3:0]      routeSelectorField;
  logic            fastSwitchBit;

  // Write channel: address and data latched independently in either order.
  logic                  awHeld;
  logic                  wHeld;
  logic [PCG_ADDR_W-1:0] awAddr;
  logic [31:0]           wData;
  logic [3:0]            wStrb;
  logic                  doWrite;
  logic [7:0]            wIdx;
  logic                  wHit;

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wIdx    = 8'(awAddr[PCG_ADDR_W-1:2]);
  assign wHit    = (awAddr[1:0] == 2'h0) &&
                   (wIdx == PCG_IDX_PAD_OUTPUT_ENABLE ||
                    wIdx == PCG_IDX_PAD_OUTPUT_VALUE ||
                    wIdx == PCG_IDX_SIGNAL_OUT_SELECT ||
                    wIdx == PCG_IDX_PAD_INPUT_LEVEL);

  // Address ready is a one-cycle pulse; no new address while one is held.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end
  end

  // Data ready is a one-cycle pulse; no new data while a word is held.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end
  end

  // The response stands until the master takes it.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PCG_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wHit ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      padOutputEnable    <= PCG_RST_PAD_OUTPUT_ENABLE;
      padOutputValue     <= PCG_RST_PAD_OUTPUT_VALUE;
      routeSelectorField <= PCG_RST_ROUTE_SELECTOR;
      fastSwitchBit      <= PCG_RST_FAST_SWITCH;
    end else if (doWrite && wStrb[0] && awAddr[1:0] == 2'h0) begin
      if (wIdx == PCG_IDX_PAD_OUTPUT_ENABLE) begin
        padOutputEnable <= wData[7:0];
      end else if (wIdx == PCG_IDX_PAD_OUTPUT_VALUE) begin
        padOutputValue <= wData[7:0];
      end else if (wIdx == PCG_IDX_SIGNAL_OUT_SELECT) begin
        routeSelectorField <= wData[PCG_ROUTE_MSB:0];
        fastSwitchBit      <= wData[PCG_FAST_SWITCH_BIT];
      end
    end
  end

  // Read channel.
  logic [7:0] rIdx;
  assign rIdx = 8'(s_axi_araddr[PCG_ADDR_W-1:2]);

  // Read address ready pulses only while no read data is pending.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= PCG_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= PCG_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr[1:0] != 2'h0) begin
          s_axi_rresp <= PCG_RESP_SLVERR;
        end else if (rIdx == PCG_IDX_PAD_OUTPUT_ENABLE) begin
          s_axi_rdata[7:0] <= padOutputEnable;
        end else if (rIdx == PCG_IDX_PAD_OUTPUT_VALUE) begin
          s_axi_rdata[7:0] <= padOutputValue;
        end else if (rIdx == PCG_IDX_PAD_INPUT_LEVEL) begin
          s_axi_rdata[7:0] <= padInputLevel;
        end else if (rIdx == PCG_IDX_SIGNAL_OUT_SELECT) begin
          s_axi_rdata[7:0] <= {fastSwitchBit, 3'b000, routeSelectorField};
        end else begin
          s_axi_rresp <= PCG_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Pad drivers, one per pin; registered so outputs come from flip-flops.
  logic [7:0] next_padOe;
  logic [7:0] next_pad_output_value;
  genvar gi;
  generate
    for (gi = 0; gi < PCG_NUM_PINS; gi++) begin : gPin
      if (gi <= PCG_SCAN_PIN_MSB) begin : gScan
        assign next_padOe[gi] = padOutputEnable[gi] && !scanEnabled;
      end else begin : gPlain
        assign next_padOe[gi] = padOutputEnable[gi];
      end
      if (gi == PCG_PIN_CLOCK_OUT) begin : gClk
        assign next_pad_output_value[gi] = padOutputEnable[gi] ?
                                 padOutputValue[gi] : clockFunction;
      end else begin : gVal
        assign next_pad_output_value[gi] = padOutputValue[gi];
      end
    end
  endgenerate

  // The clock pin is always driven: by its clock function or the register.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      padOe <= 8'h40;
    end else begin
      padOe <= next_padOe | 8'h40;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pad_output_value <= 8'h00;
    end else begin
      pad_output_value <= next_pad_output_value;
    end
  end

  // One register stage on the pad levels before they are read back.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      padInputLevel <= 8'h00;
    end else begin
      padInputLevel <= pad_input_level;
    end
  end

  logic next_signal_output_pin;
  logic next_sigOe;
  always_comb begin
    next_signal_output_pin = 1'b0;
    next_sigOe  = 1'b1;
    case (routeSelectorField)
      PCG_SEL_HIZ0, PCG_SEL_HIZ1: begin
        next_sigOe = 1'b0;
      end
      PCG_SEL_LOW: begin
        next_signal_output_pin = 1'b0;
      end
      PCG_SEL_HIGH: begin
        next_signal_output_pin = 1'b1;
      end
      PCG_SEL_TX_ENV: begin
        next_signal_output_pin = txEnvelope;
      end
      PCG_SEL_TX_ACT: begin
        next_signal_output_pin = txActive;
      end
      PCG_SEL_SECURE: begin
        next_signal_output_pin = genericSecureSignal;
      end
      PCG_SEL_RX_ENV: begin
        next_signal_output_pin = rxEnvelope;
      end
      PCG_SEL_RX_ACT: begin
        next_signal_output_pin = rxActive;
      end
      PCG_SEL_RX_BITS: begin
        next_signal_output_pin = rxBits;
      end
      default: begin
        // Reserved codes float the pin rather than drive an undefined level.
        next_sigOe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      signalOutputPin <= 1'b0;
    end else begin
      signalOutputPin <= next_signal_output_pin;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      signalOutputOe <= 1'b0;
    end else begin
      signalOutputOe <= next_sigOe;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      fastSwitch <= PCG_RST_FAST_SWITCH;
    end else begin
      fastSwitch <= fastSwitchBit;
    end
  end

endmodule : pcg_pin_config_gpio

// >>> pcg_pkg.sv
// Package with register map, field positions and codes of the pin block.
package pcg_pkg;

  // Register offsets are word indices; the byte address is four times one.
  localparam logic [7:0] PCG_IDX_PAD_OUTPUT_ENABLE = 8'h44;
  localparam logic [7:0] PCG_IDX_PAD_OUTPUT_VALUE  = 8'h45;
  localparam logic [7:0] PCG_IDX_PAD_INPUT_LEVEL   = 8'h46;
  localparam logic [7:0] PCG_IDX_SIGNAL_OUT_SELECT = 8'h47;
  localparam int         PCG_ADDR_W                = 10;

  localparam logic [7:0] PCG_RST_PAD_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0] PCG_RST_PAD_OUTPUT_VALUE  = 8'h00;
  localparam logic [3:0] PCG_RST_ROUTE_SELECTOR    = 4'h0;
  localparam logic       PCG_RST_FAST_SWITCH       = 1'b0;

  localparam int PCG_FAST_SWITCH_BIT = 7;
  localparam int PCG_ROUTE_MSB       = 3;
  localparam int PCG_SCAN_PIN_MSB    = 3;
  localparam int PCG_PIN_CLOCK_OUT   = 6;
  localparam int PCG_NUM_PINS        = 8;

  typedef enum logic [3:0] {
    PCG_SEL_HIZ0     = 4'h0,
    PCG_SEL_HIZ1     = 4'h1,
    PCG_SEL_LOW      = 4'h2,
    PCG_SEL_HIGH     = 4'h3,
    PCG_SEL_TX_ENV   = 4'h4,
    PCG_SEL_TX_ACT   = 4'h5,
    PCG_SEL_SECURE   = 4'h6,
    PCG_SEL_RX_ENV   = 4'h7,
    PCG_SEL_RX_ACT   = 4'h8,
    PCG_SEL_RX_BITS  = 4'h9
  } pcg_route_t;

  localparam logic [1:0] PCG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PCG_RESP_SLVERR = 2'h2;

endpackage : pcg_pkg

// >>> pcg_pin_config_gpio_sva.sv
// Checker of pad, selector and bus behaviour of the pin block.
`timescale 1ns/1ps
module pcg_pin_config_gpio_sva
  import pcg_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rst_b,
  input wire logic [PCG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [7:0]            pad_output_value,
  input wire logic [7:0]            padOe,
  input wire logic                  scanEnabled,
  input wire logic                  clockFunction,
  input wire logic                  txEnvelope,
  input wire logic                  txActive,
  input wire logic                  genericSecureSignal,
  input wire logic                  rxEnvelope,
  input wire logic                  rxActive,
  input wire logic                  rxBits,
  input wire logic                  signalOutputPin,
  input wire logic                  signalOutputOe,
  input wire logic                  fastSwitch
);
  logic [PCG_ADDR_W-1:0] wa;
  logic [7:0] wd, en, val, sel;
  logic [5:0] srcQ;
  logic [1:0] up;
  logic       on;
  // Shadow registers follow each OKAY write when its response is taken.
  assign on = (up == 2'h3) && !s_axi_bvalid;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      up <= 2'h0;
      en <= 8'h00;
      val <= 8'h00;
      sel <= 8'h00;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == PCG_RESP_OKAY) begin
        if (wa == {PCG_IDX_PAD_OUTPUT_ENABLE, 2'b00}) en <= wd;
        if (wa == {PCG_IDX_PAD_OUTPUT_VALUE, 2'b00}) val <= wd;
        if (wa == {PCG_IDX_SIGNAL_OUT_SELECT, 2'b00}) sel <= wd;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
    srcQ <= {rxBits, rxActive, rxEnvelope, genericSecureSignal, txActive,
             txEnvelope};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_OE_MAP: assert property (
    on |-> padOe[7:4] == {en[7], 1'b1, en[5:4]}) else $error("oe high");
  AST_SCAN_MASK: assert property (
    on |-> padOe[3:0] == ($past(scanEnabled) ? 4'h0 : en[3:0]))
    else $error("scan mask");
  AST_OUT_VAL: assert property (
    on |-> ((pad_output_value ^ val) & padOe & 8'hBF) == 8'h00) else $error("out");
  AST_CLK_PIN: assert property (
    on |-> pad_output_value[6] == (en[6] ? val[6] : $past(clockFunction)))
    else $error("clock pin");
  AST_SEL_FIXED: assert property (
    on && sel[3:0] < 4'h4 |-> signalOutputOe == sel[1] &&
    (!sel[1] || signalOutputPin == sel[0])) else $error("fixed level");
  AST_SEL_ROUTE: assert property (
    on && sel[3:0] inside {[4'h4:4'h9]} |-> signalOutputOe &&
    signalOutputPin == srcQ[sel[3:0] - 4'h4]) else $error("route");
  AST_FAST: assert property (
    on |-> fastSwitch == sel[7]) else $error("fast switch");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp hold");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (on && sel[3:0] == 4'h9);
  cover property (on && scanEnabled && en[0]);
endmodule : pcg_pin_config_gpio_sva

// >>> pcg_board_model.sv
// Board model that resolves each pad from the block or the board.
`timescale 1ns/1ps
module pcg_board_model (
  input  wire logic [7:0] pad_output_value,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] boardDrive,
  output logic      [7:0] pad_input_level
);
  // A driven pad reads back its own level; an idle pad shows the board.
  assign pad_input_level = (pad_output_value & padOe) | (boardDrive & ~padOe);
endmodule : pcg_board_model

// >>> pcg_pin_config_gpio_tb_top.sv
// Top testbench of the pin configuration block.
`timescale 1ns/1ps
module pcg_pin_config_gpio_tb_top
  import pcg_pkg::*;
;
  localparam logic [9:0] aEn = {PCG_IDX_PAD_OUTPUT_ENABLE, 2'b00};
  localparam logic [9:0] aVal = {PCG_IDX_PAD_OUTPUT_VALUE, 2'b00};
  localparam logic [9:0] aIn = {PCG_IDX_PAD_INPUT_LEVEL, 2'b00};
  localparam logic [9:0] aSel = {PCG_IDX_SIGNAL_OUT_SELECT, 2'b00};
  logic mclk = 1'b0, rst_b = 1'b0, scanEnabled = 1'b0, clockFunction = 1'b0;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, txEnvelope = 1'b0;
  logic txActive = 1'b0, genericSecureSignal = 1'b0, rxEnvelope = 1'b0;
  logic rxActive = 1'b0, rxBits = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, signalOutputPin;
  logic signalOutputOe, fastSwitch;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pad_input_level, pad_output_value, padOe, boardDrive = 8'h00;
  int errors = 0, compares = 0, cyc = 0;
  pcg_pin_config_gpio pcg_pin_config_gpio_i (.*);
  pcg_board_model pcg_board_model_i (.pad_output_value(pad_output_value), .padOe(padOe),
    .boardDrive(boardDrive), .pad_input_level(pad_input_level));
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d, r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(r), 32'(s_axi_bresp));
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] d, r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(r), 32'(s_axi_rresp));
    chk("rdata", 32'(d), s_axi_rdata);
  endtask : rd
  task automatic t_pads();
    clockFunction <= 1'b1;
    wr(aVal, 8'hA5, PCG_RESP_OKAY);
    wr(aEn, 8'hFF, PCG_RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("padOe", 32'hFF, 32'(padOe));
    chk("pad_output_value", 32'hA5, 32'(pad_output_value));
    rd(aIn, 8'hA5, PCG_RESP_OKAY);
    scanEnabled <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("padOe", 32'hF0, 32'(padOe));
    wr(aEn, 8'h00, PCG_RESP_OKAY);
    boardDrive <= 8'h3C;
    repeat (3) @(posedge mclk);
    chk("padOut6", 32'h1, 32'(pad_output_value[6]));
    rd(aIn, 8'h7C, PCG_RESP_OKAY);
    scanEnabled <= 1'b0;
    $display("test pads done");
  endtask : t_pads
  task automatic t_sel();
    logic [3:0] c;
    logic [5:0] p;
    for (int i = 0; i < 10; i++) begin
      c = 4'(i);
      wr(aSel, {c[0], 3'b111, c}, PCG_RESP_OKAY);
      rd(aSel, {c[0], 3'b000, c}, PCG_RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
        p = (k == 1) ? 6'h2A : 6'h15;
        {rxBits, rxActive, rxEnvelope, genericSecureSignal, txActive,
         txEnvelope} <= p;
        repeat (3) @(posedge mclk);
        chk("fast", 32'(c[0]), 32'(fastSwitch));
        chk("sigOe", 32'(c > 4'h1), 32'(signalOutputOe));
        if (c > 4'h1) chk("sigPin", 32'(c == 4'h3 ||
          (c > 4'h3 && p[c - 4'h4])), 32'(signalOutputPin));
      end
    end
    $display("test selector done");
  endtask : t_sel
  task automatic t_err();
    wr(10'h120, 8'hFF, PCG_RESP_SLVERR);
    wr(aEn + 10'h1, 8'hFF, PCG_RESP_SLVERR);
    wr(aIn, 8'hFF, PCG_RESP_OKAY);
    rd(aEn, 8'h00, PCG_RESP_OKAY);
    rd(10'h120, 8'h00, PCG_RESP_SLVERR);
    wr(aEn, 8'hFF, PCG_RESP_OKAY);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("padOe", 32'h40, 32'(padOe));
    rd(aEn, 8'h00, PCG_RESP_OKAY);
    rd(aSel, 8'h00, PCG_RESP_OKAY);
    $display("test errors and reset done");
  endtask : t_err
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_pads();
    t_sel();
    t_err();
    finish_test();
  end
endmodule : pcg_pin_config_gpio_tb_top
bind pcg_pin_config_gpio pcg_pin_config_gpio_sva
  pcg_pin_config_gpio_sva_i (.*);
